// ---- bench/test_ulf_uart_core.sv ----
// Purpose: register and serial tests for ulf_uart_core
// Assumes: divisor 1 or 2
// Notes:   peer model plays the remote terminal
`timescale 1ns/1ps
`default_nettype none
module test_ulf_uart_core;
   logic       core_clk = 1'b0;
   logic       rst = 1'b1;
   logic [2:0] addr = 3'h0;
   logic       wr_stb = 1'b0;
   logic       rd_stb = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata, v, d, m, lc;
   logic       rx_line, tx_line, p, ep, dtr, rts;
   int         fail_count = 0;
   int         comparisons = 0;
   int         t0, nb, ex;
   logic [7:0] lcrs [8] = '{8'h00, 8'h04, 8'h05, 8'h0A, 8'h1B, 8'h3B, 8'h2F, 8'h03};
   logic [7:0] dats [8] = '{8'h15, 8'h0A, 8'h2B, 8'h55, 8'hC3, 8'h81, 8'h7E, 8'hA5};
   always #2 core_clk = ~core_clk;
   ulf_uart_core i_dut (.core_clk(core_clk), .rst(rst), .addr(addr), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .wdata(wdata), .rdata(rdata), .serial_rx_line(rx_line),
      .serial_tx_line(tx_line), .cts_n(1'b1), .dsr_n(1'b1), .ri_n(1'b1), .dcd_n(1'b1),
      .dtr_n(dtr), .rts_n(rts));
   ulf_serial_peer i_peer (.clk(core_clk), .line_in(tx_line), .line_out(rx_line));
   task automatic wr(input logic [2:0] a, input logic [7:0] x);
      addr = a;
      wdata = x;
      wr_stb = 1'b1;
      @(posedge core_clk);
      #1 wr_stb = 1'b0;
      @(posedge core_clk);
      #1;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] x);
      addr = a;
      rd_stb = 1'b1;
      @(posedge core_clk);
      #1 rd_stb = 1'b0;
      @(posedge core_clk);
      #1 x = rdata;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkr(input int got, input int lo, input int hi);
      comparisons++;
      if (got < lo || got > hi) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
      end
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge core_clk);
      #1 rst = 1'b0;
      rd(3'h5, v);
      chk(v, 8'h60);
      wr(3'h7, 8'hA5);
      rd(3'h7, v);
      chk(v, 8'hA5);
      wr(3'h3, 8'h80);
      wr(3'h0, 8'h34);
      wr(3'h1, 8'h12);
      rd(3'h0, v);
      chk(v, 8'h34);
      rd(3'h1, v);
      chk(v, 8'h12);
      wr(3'h3, 8'h00);
      wr(3'h5, 8'hFF);
      rd(3'h5, v);
      chk(v, 8'h60);
      $display("registers done");
      for (int i = 0; i < 8; i++) begin
         lc = lcrs[i];
         nb = 5 + lc[1:0];
         m = 8'hFF >> (3 - lc[1:0]);
         ep = lc[5] ? ~lc[4] : (lc[4] ? ^(dats[i] & m) : ~^(dats[i] & m));
         ex = (i / 7 + 1) * (16 * (1 + nb + lc[3]) + (!lc[2] ? 16 : (nb == 5 ? 24 : 32)));
         wr(3'h3, 8'h80);
         wr(3'h0, 8'(i / 7 + 1));
         wr(3'h1, 8'h00);
         wr(3'h3, lc);
         wr(3'h0, dats[i]);
         i_peer.recv(nb, lc[3], 16 * (i / 7 + 1), d, p, t0);
         chk(d, dats[i] & m);
         chk({7'h00, p}, {7'h00, ep & lc[3]});
         v = 8'h00;
         for (int k = 0; k < 200 && !v[6]; k++) rd(3'h5, v);
         chkr(i_peer.cyc - t0, ex - 3, ex + 6);
      end
      $display("transmit formats done");
      wr(3'h3, 8'h43);
      repeat (50) @(posedge core_clk);
      #1 chk({7'h00, tx_line}, 8'h00);
      wr(3'h3, 8'h03);
      repeat (3) @(posedge core_clk);
      #1 chk({7'h00, tx_line}, 8'h01);
      $display("break done");
      wr(3'h4, 8'h01);
      rd(3'h4, v);
      chk(v, 8'h01);
      chk({6'h00, rts, dtr}, 8'h02);
      $display("modem control done");
      wr(3'h3, 8'h80);
      wr(3'h0, 8'h01);
      wr(3'h3, 8'h1B);
      i_peer.send(8'h5A, 8, 1, 16);
      rd(3'h5, v);
      chk(v, 8'h65);
      rd(3'h0, v);
      chk(v, 8'h5A);
      rd(3'h5, v);
      chk(v, 8'h60);
      for (int i = 0; i < 34; i++) i_peer.send(8'(i), 8, ^8'(i), 16);
      rd(3'h5, v);
      chk(v & 8'h03, 8'h03);
      rd(3'h5, v);
      chk(v & 8'h02, 8'h00);
      for (int i = 0; i < 33; i++) begin
         rd(3'h0, v);
         chk(v, 8'(i));
      end
      rd(3'h5, v);
      chk(v & 8'h01, 8'h00);
      $display("receive done");
      results();
   end
   initial begin
      #100000;
      fail_count++;
      results();
   end
endmodule
`default_nettype wire

// ---- bench/ulf_serial_peer.sv ----
// Purpose: remote terminal model on the serial pair
// Assumes: bit period given in core clocks
// Notes:   line idles high between frames
`timescale 1ns/1ps
`default_nettype none
module ulf_serial_peer (
   input  wire logic clk,
   input  wire logic line_in,
   output var  logic line_out
);
   int cyc = 0;
   initial line_out = 1'b1;
   always @(posedge clk) cyc <= cyc + 1;
   task automatic drv(input logic b, input int per);
      line_out = b;
      repeat (per) @(posedge clk);
      #1;
   endtask
   // par below zero sends no parity bit
   task automatic send(input logic [7:0] d, input int nb, input int par, input int per);
      drv(1'b0, per);
      for (int i = 0; i < nb; i++) begin
         drv(d[i], per);
      end
      if (par >= 0) begin
         drv(par[0], per);
      end
      drv(1'b1, 2 * per);
   endtask
   task automatic recv(input int nb, input logic parity_on, input int per, output logic [7:0] d,
                       output logic p, output int t0);
      d = 8'h00;
      p = 1'b0;
      @(negedge line_in);
      @(posedge clk);
      t0 = cyc;
      repeat (per / 2) @(posedge clk);
      for (int i = 0; i < nb + parity_on; i++) begin
         repeat (per) @(posedge clk);
         if (i < nb) d[i] = line_in;
         else p = line_in;
      end
   endtask
endmodule
`default_nettype wire

// ---- bench/ulf_uart_core_chk.sv ----
// Purpose: port checker for ulf_uart_core
// Assumes: divisor fixed within a frame
// Notes:   shadows format and divisor bytes
`timescale 1ns/1ps
`default_nettype none
module ulf_uart_core_chk (
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic [2:0] addr,
   input wire logic       wr_stb,
   input wire logic       rd_stb,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic       serial_tx_line
);
   logic [7:0]  line_format_control, next_lcr;
   logic [15:0] dv, next_dv;
   logic [23:0] low_n, next_low_n;
   logic        brk, next_brk;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   always_comb begin
      next_lcr = (wr_stb && addr == 3'h3) ? wdata : line_format_control;
      next_dv = dv;
      if (wr_stb && line_format_control[7] && addr == 3'h0) begin
         next_dv[7:0] = wdata;
      end
      if (wr_stb && line_format_control[7] && addr == 3'h1) begin
         next_dv[15:8] = wdata;
      end
      next_low_n = serial_tx_line ? 24'h000000 : low_n + 24'h000001;
      next_brk = !serial_tx_line && (brk || line_format_control[6]);
   end
   always_ff @(posedge core_clk) begin
      line_format_control <= rst ? 8'h00 : next_lcr;
      dv <= rst ? 16'h0000 : next_dv;
      low_n <= rst ? 24'h000000 : next_low_n;
      brk <= rst ? 1'b0 : next_brk;
   end
   a_reset_idle: assert property ($fell(rst) |-> serial_tx_line && rdata == 8'h00)
      else $error("outputs not idle after reset");
   a_break_drive: assert property (wr_stb && addr == 3'h3 && wdata[6] |-> ##[2:3] !serial_tx_line)
      else $error("break did not drive line low");
   a_break_hold: assert property (line_format_control[6] && $past(line_format_control[6]) && $past(line_format_control[6], 2) |-> !serial_tx_line)
      else $error("line rose during break");
   a_status_top: assert property (rd_stb && addr == 3'h5 |=> !rdata[7])
      else $error("status bit 7 set");
   a_overrun_clear: assert property (rd_stb && addr == 3'h5 ##2 rd_stb && addr == 3'h5 |=> !rdata[1])
      else $error("overrun not cleared by status read");
   a_div_read: assert property (rd_stb && line_format_control[7] && addr[2:1] == 2'h0 |=> rdata == ($past(addr[0]) ? dv[15:8] : dv[7:0]))
      else $error("divisor byte readback wrong");
   a_format_read: assert property (rd_stb && addr == 3'h3 |=> rdata == line_format_control)
      else $error("line format readback wrong");
   a_bit_period: assert property ($rose(serial_tx_line) && !brk && dv != 16'h0000 |-> low_n % (dv * 16) == 0)
      else $error("low run not whole bit times");
   cover property (wr_stb && addr == 3'h3 && wdata[6]);
   cover property ($rose(serial_tx_line) && !brk);
   cover property (rd_stb && addr == 3'h5 ##2 rdata[1]);
endmodule
bind ulf_uart_core ulf_uart_core_chk i_chk (.core_clk, .rst, .addr, .wr_stb, .rd_stb, .wdata,
   .rdata, .serial_tx_line);
`default_nettype wire

// ---- rtl/ulf_fifo.sv ----
// Purpose: synchronous word fifo
// Assumes: depth is a power of two
// Notes:   ready low when full, valid low when empty
`timescale 1ns/1ps
`default_nettype none
module ulf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic    clk,
   input wire logic    rst,
   ulf_stream_if.snk   wr,
   ulf_stream_if.src   rd
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp;
   logic [AW-1:0]    rp;
   logic [AW:0]      cnt;
   logic [AW-1:0]    next_wp;
   logic [AW-1:0]    next_rp;
   logic [AW:0]      next_cnt;
   logic             push;
   logic             pop;

   assign wr.ready = (cnt != FULL);
   assign rd.valid = (cnt != '0);
   assign rd.data  = mem[rp];
   assign push     = wr.valid && wr.ready;
   assign pop      = rd.valid && rd.ready;

   always_comb begin
      next_wp  = push ? AW'(wp + 1'b1) : wp;
      next_rp  = pop ? AW'(rp + 1'b1) : rp;
      next_cnt = cnt;
      if (push && !pop) begin
         next_cnt = (AW+1)'(cnt + 1'b1);
      end else if (pop && !push) begin
         next_cnt = (AW+1)'(cnt - 1'b1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wp  <= '0;
         rp  <= '0;
         cnt <= '0;
      end else begin
         wp  <= next_wp;
         rp  <= next_rp;
         cnt <= next_cnt;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp] <= wr.data;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/ulf_pkg.sv ----
// Purpose: shared constants and types for the line format / baud block
// Assumes: byte-wide host port, 3-bit register offset
// Notes:   character mode only; rx fifo sits between shifter and buffer
package ulf_pkg;
   localparam logic [2:0] OFS_DATA = 3'h0;
   localparam logic [2:0] OFS_IER  = 3'h1;
   localparam logic [2:0] OFS_IIR  = 3'h2;
   localparam logic [2:0] OFS_LCR  = 3'h3;
   localparam logic [2:0] OFS_MCR  = 3'h4;
   localparam logic [2:0] OFS_LSR  = 3'h5;
   localparam logic [2:0] OFS_MSR  = 3'h6;
   localparam logic [2:0] OFS_SCR  = 3'h7;

   localparam int LCR_STOP  = 2;
   localparam int LCR_PAR   = 3;
   localparam int LCR_EVEN  = 4;
   localparam int LCR_FIX   = 5;
   localparam int LCR_BRK   = 6;
   localparam int LCR_DIVISOR_ACCESS_SELECT  = 7;
   localparam int MCR_DTR   = 0;
   localparam int MCR_RTS   = 1;

   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] IER_MASK = 8'h0F;
   localparam logic [7:0] MCR_MASK = 8'h1F;
   localparam logic [7:0] IIR_IDLE = 8'h01;
   localparam logic [15:0] DIV_RST = 16'h0000;

   localparam logic [4:0] TICK_MID  = 5'h07;
   localparam logic [4:0] TICK_LAST = 5'h0F;
   localparam logic [4:0] STOP_1    = 5'h0F;
   localparam logic [4:0] STOP_15   = 5'h17;
   localparam logic [4:0] STOP_2    = 5'h1F;

   localparam int RX_DEPTH = 32;
   localparam int RX_W     = 11;
   localparam int RXW_PE   = 8;
   localparam int RXW_FE   = 9;
   localparam int RXW_BI   = 10;

   typedef enum logic [4:0] {
      ULF_IDLE  = 5'b00001,
      ULF_START = 5'b00010,
      ULF_DATA  = 5'b00100,
      ULF_PAR   = 5'b01000,
      ULF_STOP  = 5'b10000
   } ulf_state_t;

   // last data bit index for the length code
   function automatic logic [2:0] ulf_last_bit(input logic [7:0] line_format_control);
      return 3'h4 + {1'b0, line_format_control[1:0]};
   endfunction

   // data bits above the length read as zero
   function automatic logic [7:0] ulf_mask(input logic [7:0] line_format_control);
      return 8'hFF >> (2'h3 - line_format_control[1:0]);
   endfunction

   // parity bit to send or expect
   function automatic logic ulf_parity(input logic [7:0] line_format_control, input logic [7:0] d);
      logic p;
      p = ^(d & ulf_mask(line_format_control));
      if (line_format_control[LCR_FIX]) begin
         return ~line_format_control[LCR_EVEN];
      end
      return line_format_control[LCR_EVEN] ? p : ~p;
   endfunction
endpackage

// ---- rtl/ulf_stream_if.sv ----
// Purpose: valid/ready word carrier between block modules
// Assumes: one clock
// Notes:   word taken when valid and ready are both high
`timescale 1ns/1ps
`default_nettype none
interface ulf_stream_if #(parameter int WIDTH = 8);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- rtl/ulf_uart_core.sv ----
// Purpose: character framing, line status and baud generator
// Assumes: host strobes and serial input synchronous to core_clk
// Notes:   character mode; received words queue in a 32 word fifo
`timescale 1ns/1ps
`default_nettype none
module ulf_uart_core (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic [2:0] addr,
   input  wire logic       wr_stb,
   input  wire logic       rd_stb,
   input  wire logic [7:0] wdata,
   output var  logic [7:0] rdata,
   input  wire logic       serial_rx_line,
   output var  logic       serial_tx_line,
   input  wire logic       cts_n,
   input  wire logic       dsr_n,
   input  wire logic       ri_n,
   input  wire logic       dcd_n,
   output var  logic       dtr_n,
   output var  logic       rts_n
);
   // host registers and status
   logic [7:0]  line_format_control, ier, modem_control, scratch_byte, thr, rbr;
   logic [15:0] divisor;
   logic        tx_holding_empty, dr, oe, pe, fe, bi;
   logic [3:0]  msr_delta, modem_prev;
   logic [7:0]  next_lcr, next_ier, next_mcr, next_scr, next_thr, next_rbr, next_rdata;
   logic [15:0] next_divisor;
   logic        next_tx_holding_empty, next_dr, next_oe, next_pe, next_fe, next_bi;
   logic        next_dtr_n, next_rts_n;
   logic [3:0]  next_msr_delta, modem_now;
   logic        div_wr, divisor_access_select, pop_ok;
   // baud
   logic [15:0] baud_cnt, next_baud_cnt;
   logic        tick, next_tick;
   // transmitter
   ulf_pkg::ulf_state_t tx_st, next_tx_st;
   logic [7:0]  tx_sh, next_tx_sh;
   logic [2:0]  tx_bit, next_tx_bit;
   logic [4:0]  tx_tk, next_tx_tk;
   logic        tx_pbit, next_tx_pbit, next_tx_line, tx_take;
   // receiver
   ulf_pkg::ulf_state_t rx_st, next_rx_st;
   logic [7:0]  rx_sh, next_rx_sh;
   logic [2:0]  rx_bit, next_rx_bit;
   logic [4:0]  rx_tk, next_rx_tk;
   logic        rx_pbit, next_rx_pbit;
   logic        rx_push, next_rx_push;
   logic [ulf_pkg::RX_W-1:0] rx_word, next_rx_word;

   ulf_stream_if #(.WIDTH(ulf_pkg::RX_W)) rx_in ();
   ulf_stream_if #(.WIDTH(ulf_pkg::RX_W)) rx_out ();

   assign rx_in.valid  = rx_push;
   assign rx_in.data   = rx_word;
   assign rx_out.ready = pop_ok;

   ulf_fifo #(.WIDTH(ulf_pkg::RX_W), .DEPTH(ulf_pkg::RX_DEPTH)) u_rx_fifo (
      .clk (core_clk),
      .rst (rst),
      .wr  (rx_in),
      .rd  (rx_out)
   );

   assign divisor_access_select      = line_format_control[ulf_pkg::LCR_DIVISOR_ACCESS_SELECT];
   assign modem_now = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n};
   assign tx_take   = (tx_st == ulf_pkg::ULF_IDLE) && !tx_holding_empty;
   // buffer may take a word when empty or being read this cycle
   assign pop_ok    = !dr || (rd_stb && addr == ulf_pkg::OFS_DATA && !divisor_access_select);

   // register file
   always_comb begin
      next_lcr       = line_format_control;
      next_ier       = ier;
      next_mcr       = modem_control;
      next_scr       = scratch_byte;
      next_thr       = thr;
      next_rbr       = rbr;
      next_divisor   = divisor;
      next_tx_holding_empty      = tx_holding_empty;
      next_dr        = dr;
      next_oe        = oe;
      next_pe        = pe;
      next_fe        = fe;
      next_bi        = bi;
      next_msr_delta = msr_delta;
      next_rdata     = rdata;
      div_wr         = 1'b0;
      if (tx_take) begin
         next_tx_holding_empty = 1'b1;
      end
      if (wr_stb) begin
         case (addr)
            ulf_pkg::OFS_DATA: begin
               if (divisor_access_select) begin
                  next_divisor[7:0] = wdata;
                  div_wr = 1'b1;
               end else begin
                  next_thr  = wdata;
                  next_tx_holding_empty = 1'b0;
               end
            end
            ulf_pkg::OFS_IER: begin
               if (divisor_access_select) begin
                  next_divisor[15:8] = wdata;
                  div_wr = 1'b1;
               end else begin
                  next_ier = wdata & ulf_pkg::IER_MASK;
               end
            end
            ulf_pkg::OFS_LCR: next_lcr = wdata;
            ulf_pkg::OFS_MCR: next_mcr = wdata & ulf_pkg::MCR_MASK;
            ulf_pkg::OFS_SCR: next_scr = wdata;
            default: ;
         endcase
      end
      if (rd_stb) begin
         case (addr)
            ulf_pkg::OFS_DATA: begin
               next_rdata = divisor_access_select ? divisor[7:0] : rbr;
               if (!divisor_access_select) begin
                  next_dr = 1'b0;
               end
            end
            ulf_pkg::OFS_IER: next_rdata = divisor_access_select ? divisor[15:8] : ier;
            ulf_pkg::OFS_IIR: next_rdata = ulf_pkg::IIR_IDLE;
            ulf_pkg::OFS_LCR: next_rdata = line_format_control;
            ulf_pkg::OFS_MCR: next_rdata = modem_control;
            ulf_pkg::OFS_LSR: begin
               // top bit stays zero in character mode
               next_rdata = {1'b0, tx_holding_empty && tx_st == ulf_pkg::ULF_IDLE, tx_holding_empty,
                             bi, fe, pe, oe, dr};
               next_oe = 1'b0;
               next_pe = 1'b0;
               next_fe = 1'b0;
               next_bi = 1'b0;
            end
            ulf_pkg::OFS_MSR: begin
               next_rdata     = {modem_now, msr_delta};
               next_msr_delta = 4'h0;
            end
            default: next_rdata = scratch_byte;
         endcase
      end
      // hardware sets win over read clears
      next_msr_delta = next_msr_delta | {modem_now[3] ^ modem_prev[3],
                       ~modem_now[2] & modem_prev[2], modem_now[1:0] ^ modem_prev[1:0]};
      if (rx_push && !rx_in.ready) begin
         next_oe = 1'b1;
      end
      if (rx_out.valid && pop_ok) begin
         next_rbr = rx_out.data[7:0];
         next_dr  = 1'b1;
         next_pe  = next_pe | rx_out.data[ulf_pkg::RXW_PE];
         next_fe  = next_fe | rx_out.data[ulf_pkg::RXW_FE];
         next_bi  = next_bi | rx_out.data[ulf_pkg::RXW_BI];
      end
      next_dtr_n = ~next_mcr[ulf_pkg::MCR_DTR];
      next_rts_n = ~next_mcr[ulf_pkg::MCR_RTS];
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         line_format_control        <= ulf_pkg::RST_BYTE;
         ier        <= ulf_pkg::RST_BYTE;
         modem_control        <= ulf_pkg::RST_BYTE;
         scratch_byte        <= ulf_pkg::RST_BYTE;
         thr        <= ulf_pkg::RST_BYTE;
         rbr        <= ulf_pkg::RST_BYTE;
         rdata      <= ulf_pkg::RST_BYTE;
         divisor    <= ulf_pkg::DIV_RST;
         tx_holding_empty       <= 1'b1;
         dr         <= 1'b0;
         oe         <= 1'b0;
         pe         <= 1'b0;
         fe         <= 1'b0;
         bi         <= 1'b0;
         msr_delta  <= 4'h0;
         modem_prev <= 4'h0;
         dtr_n      <= 1'b1;
         rts_n      <= 1'b1;
      end else begin
         line_format_control        <= next_lcr;
         ier        <= next_ier;
         modem_control        <= next_mcr;
         scratch_byte        <= next_scr;
         thr        <= next_thr;
         rbr        <= next_rbr;
         rdata      <= next_rdata;
         divisor    <= next_divisor;
         tx_holding_empty       <= next_tx_holding_empty;
         dr         <= next_dr;
         oe         <= next_oe;
         pe         <= next_pe;
         fe         <= next_fe;
         bi         <= next_bi;
         msr_delta  <= next_msr_delta;
         modem_prev <= modem_now;
         dtr_n      <= next_dtr_n;
         rts_n      <= next_rts_n;
      end
   end

   // baud generator: one tick every divisor clocks
   always_comb begin
      next_tick     = 1'b0;
      next_baud_cnt = baud_cnt;
      if (div_wr) begin
         next_baud_cnt = next_divisor;
      end else if (baud_cnt <= 16'h0001) begin
         next_baud_cnt = divisor;
         next_tick     = (divisor != ulf_pkg::DIV_RST);
      end else begin
         next_baud_cnt = baud_cnt - 16'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         baud_cnt <= ulf_pkg::DIV_RST;
         tick     <= 1'b0;
      end else begin
         baud_cnt <= next_baud_cnt;
         tick     <= next_tick;
      end
   end

   // transmitter, sixteen ticks per bit
   always_comb begin
      next_tx_st   = tx_st;
      next_tx_sh   = tx_sh;
      next_tx_bit  = tx_bit;
      next_tx_tk   = tx_tk;
      next_tx_pbit = tx_pbit;
      if (tx_take) begin
         next_tx_st   = ulf_pkg::ULF_START;
         next_tx_sh   = thr;
         next_tx_bit  = 3'h0;
         next_tx_tk   = 5'h00;
         next_tx_pbit = ulf_pkg::ulf_parity(line_format_control, thr);
      end else if (tick && tx_st != ulf_pkg::ULF_IDLE) begin
         next_tx_tk = tx_tk + 5'h01;
         case (tx_st)
            ulf_pkg::ULF_START: begin
               if (tx_tk == ulf_pkg::TICK_LAST) begin
                  next_tx_st = ulf_pkg::ULF_DATA;
                  next_tx_tk = 5'h00;
               end
            end
            ulf_pkg::ULF_DATA: begin
               if (tx_tk == ulf_pkg::TICK_LAST) begin
                  next_tx_tk  = 5'h00;
                  next_tx_sh  = {1'b0, tx_sh[7:1]};
                  next_tx_bit = tx_bit + 3'h1;
                  if (tx_bit == ulf_pkg::ulf_last_bit(line_format_control)) begin
                     next_tx_st = line_format_control[ulf_pkg::LCR_PAR] ? ulf_pkg::ULF_PAR
                                                        : ulf_pkg::ULF_STOP;
                  end
               end
            end
            ulf_pkg::ULF_PAR: begin
               if (tx_tk == ulf_pkg::TICK_LAST) begin
                  next_tx_st = ulf_pkg::ULF_STOP;
                  next_tx_tk = 5'h00;
               end
            end
            ulf_pkg::ULF_STOP: begin
               if (!line_format_control[ulf_pkg::LCR_STOP] && tx_tk == ulf_pkg::STOP_1) begin
                  next_tx_st = ulf_pkg::ULF_IDLE;
               end else if (line_format_control[ulf_pkg::LCR_STOP] && line_format_control[1:0] == 2'h0
                            && tx_tk == ulf_pkg::STOP_15) begin
                  next_tx_st = ulf_pkg::ULF_IDLE;
               end else if (tx_tk == ulf_pkg::STOP_2) begin
                  next_tx_st = ulf_pkg::ULF_IDLE;
               end
            end
            default: next_tx_st = ulf_pkg::ULF_IDLE;
         endcase
      end
      case (tx_st)
         ulf_pkg::ULF_START: next_tx_line = 1'b0;
         ulf_pkg::ULF_DATA:  next_tx_line = tx_sh[0];
         ulf_pkg::ULF_PAR:   next_tx_line = tx_pbit;
         default:            next_tx_line = 1'b1;
      endcase
      if (line_format_control[ulf_pkg::LCR_BRK]) begin
         next_tx_line = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tx_st          <= ulf_pkg::ULF_IDLE;
         tx_sh          <= ulf_pkg::RST_BYTE;
         tx_bit         <= 3'h0;
         tx_tk          <= 5'h00;
         tx_pbit        <= 1'b0;
         serial_tx_line <= 1'b1;
      end else begin
         tx_st          <= next_tx_st;
         tx_sh          <= next_tx_sh;
         tx_bit         <= next_tx_bit;
         tx_tk          <= next_tx_tk;
         tx_pbit        <= next_tx_pbit;
         serial_tx_line <= next_tx_line;
      end
   end

   // receiver, samples mid bit
   always_comb begin
      next_rx_st   = rx_st;
      next_rx_sh   = rx_sh;
      next_rx_bit  = rx_bit;
      next_rx_tk   = rx_tk;
      next_rx_pbit = rx_pbit;
      next_rx_push = 1'b0;
      next_rx_word = rx_word;
      case (rx_st)
         ulf_pkg::ULF_IDLE: begin
            if (!serial_rx_line) begin
               next_rx_st  = ulf_pkg::ULF_START;
               next_rx_tk  = 5'h00;
               next_rx_sh  = ulf_pkg::RST_BYTE;
               next_rx_bit = 3'h0;
            end
         end
         ulf_pkg::ULF_START: begin
            if (tick) begin
               next_rx_tk = rx_tk + 5'h01;
               if (rx_tk == ulf_pkg::TICK_MID) begin
                  next_rx_tk = 5'h00;
                  next_rx_st = serial_rx_line ? ulf_pkg::ULF_IDLE
                                              : ulf_pkg::ULF_DATA;
               end
            end
         end
         ulf_pkg::ULF_DATA: begin
            if (tick) begin
               next_rx_tk = rx_tk + 5'h01;
               if (rx_tk == ulf_pkg::TICK_LAST) begin
                  next_rx_tk          = 5'h00;
                  next_rx_sh[rx_bit]  = serial_rx_line;
                  next_rx_bit         = rx_bit + 3'h1;
                  if (rx_bit == ulf_pkg::ulf_last_bit(line_format_control)) begin
                     next_rx_st = line_format_control[ulf_pkg::LCR_PAR] ? ulf_pkg::ULF_PAR
                                                        : ulf_pkg::ULF_STOP;
                  end
               end
            end
         end
         ulf_pkg::ULF_PAR: begin
            if (tick) begin
               next_rx_tk = rx_tk + 5'h01;
               if (rx_tk == ulf_pkg::TICK_LAST) begin
                  next_rx_tk   = 5'h00;
                  next_rx_pbit = serial_rx_line;
                  next_rx_st   = ulf_pkg::ULF_STOP;
               end
            end
         end
         ulf_pkg::ULF_STOP: begin
            if (tick) begin
               next_rx_tk = rx_tk + 5'h01;
               if (rx_tk == ulf_pkg::TICK_LAST) begin
                  next_rx_push = 1'b1;
                  next_rx_st   = ulf_pkg::ULF_IDLE;
                  next_rx_word = {~serial_rx_line && rx_sh == ulf_pkg::RST_BYTE
                                  && !(line_format_control[ulf_pkg::LCR_PAR] && rx_pbit),
                                  ~serial_rx_line,
                                  line_format_control[ulf_pkg::LCR_PAR]
                                  && rx_pbit != ulf_pkg::ulf_parity(line_format_control, rx_sh),
                                  rx_sh};
               end
            end
         end
         default: next_rx_st = ulf_pkg::ULF_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rx_st   <= ulf_pkg::ULF_IDLE;
         rx_sh   <= ulf_pkg::RST_BYTE;
         rx_bit  <= 3'h0;
         rx_tk   <= 5'h00;
         rx_pbit <= 1'b0;
         rx_push <= 1'b0;
         rx_word <= '0;
      end else begin
         rx_st   <= next_rx_st;
         rx_sh   <= next_rx_sh;
         rx_bit  <= next_rx_bit;
         rx_tk   <= next_rx_tk;
         rx_pbit <= next_rx_pbit;
         rx_push <= next_rx_push;
         rx_word <= next_rx_word;
      end
   end
endmodule
`default_nettype wire
